/* design/port_mux_pkg.sv */
package port_mux_pkg;

	localparam int          PORT_WIDTH    = 8;
	localparam int          ADDR_WIDTH    = 4;
	// Register map, byte offsets on the plain register port
	localparam logic [3:0]  REG_P1_IN     = 4'h0;
	localparam logic [3:0]  REG_P1_OUT    = 4'h1;
	localparam logic [3:0]  REG_P1_DIR    = 4'h2;
	localparam logic [3:0]  REG_P1_IFG    = 4'h3;
	localparam logic [3:0]  REG_P1_IES    = 4'h4;
	localparam logic [3:0]  REG_P1_IE     = 4'h5;
	localparam logic [3:0]  REG_P1_SEL    = 4'h6;
	localparam logic [3:0]  REG_P2_IN     = 4'h8;
	localparam logic [3:0]  REG_P2_OUT    = 4'h9;
	localparam logic [3:0]  REG_P2_DIR    = 4'hA;
	localparam logic [3:0]  REG_P2_IFG    = 4'hB;
	localparam logic [3:0]  REG_P2_IES    = 4'hC;
	localparam logic [3:0]  REG_P2_IE     = 4'hD;
	localparam logic [3:0]  REG_P2_SEL    = 4'hE;
	localparam logic [3:0]  REG_FUSE_STAT = 4'hF;
	localparam logic [7:0]  RESET_BYTE    = 8'h00;
	// Port-two bits with no external pin
	localparam logic [7:0]  P2_UNBONDED   = 8'hC0;
	// Fuse status bit positions
	localparam int          FS_CHECK_BIT  = 0;
	localparam int          FS_BLOWN_BIT  = 1;
	localparam int          FS_BYPASS_BIT = 2;

	typedef enum logic [1:0] {
		FUSE_IDLE  = 2'b00,
		FUSE_CHECK = 2'b01,
		FUSE_DONE  = 2'b11,
		FUSE_LOCK  = 2'b10
	} fuse_state_t;

endpackage : port_mux_pkg

/* design/port_pin_function_mux.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
module port_pin_function_mux
	import port_mux_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [ADDR_WIDTH-1:0] regAddr,
	input  wire logic [WIDTH-1:0]      regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [WIDTH-1:0]      regRdata,
	input  wire logic [WIDTH-1:0]      p1PinIn,
	output logic      [WIDTH-1:0]      p1PinOut,
	output logic      [WIDTH-1:0]      p1PinOe,
	input  wire logic [WIDTH-1:0]      p2PinIn,
	output logic      [WIDTH-1:0]      p2PinOut,
	output logic      [WIDTH-1:0]      p2PinOe,
	input  wire logic                  compareOutputCh0,
	input  wire logic                  compareOutputCh1,
	input  wire logic                  compareOutputCh2,
	input  wire logic                  submainSystemClock,
	input  wire logic                  auxClock,
	input  wire logic                  comparatorResult,
	output logic                       timerExternalClockIn,
	output logic                       timerAlternateClockIn,
	output logic                       captureCh0InputA,
	output logic                       captureCh1InputA,
	output logic                       captureCh2InputA,
	output logic                       captureCh0InputB,
	output logic                       p1IrqReq,
	output logic                       p2IrqReq,
	input  wire logic                  powerOnReset,
	input  wire logic                  debugAccess,
	input  wire logic                  testPin,
	input  wire logic                  fuseBlown,
	output logic                       fuseSenseEn,
	output logic                       debugBypass,
	output logic                       debugGrant
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	localparam int    SYNC_FILL = 3;
	logic [WIDTH-1:0] p1Out_q, p1Dir_q, p1Ifg_q, p1Ies_q, p1Ie_q, p1Sel_q;
	logic [WIDTH-1:0] p2Out_q, p2Dir_q, p2Ifg_q, p2Ies_q, p2Ie_q, p2Sel_q;
	logic [WIDTH-1:0] p1Sync1_q, p1Sync2_q, p1Prev_q;
	logic [WIDTH-1:0] p2Sync1_q, p2Sync2_q, p2Prev_q;
	logic [WIDTH-1:0] p1Edge, p2Edge, p1Mod, p2Mod;
	logic [3:0]       dbgSync1_q, dbgSync2_q;
	logic             dbgPrev_q;
	fuse_state_t      fuse_q;
	logic             wrEn;
	logic [SYNC_FILL-1:0] syncFill_q;

	assign wrEn = regWrite;

	always_ff @(posedge clk) begin
		if (rst) begin
			p1Out_q <= RESET_BYTE;
			p1Dir_q <= RESET_BYTE;
			p1Ies_q <= RESET_BYTE;
			p1Ie_q  <= RESET_BYTE;
			p1Sel_q <= RESET_BYTE;
			p2Out_q <= RESET_BYTE;
			p2Dir_q <= RESET_BYTE;
			p2Ies_q <= RESET_BYTE;
			p2Ie_q  <= RESET_BYTE;
			p2Sel_q <= RESET_BYTE;
		end else if (wrEn) begin
			unique case (regAddr)
				REG_P1_OUT: p1Out_q <= regWdata;
				REG_P1_DIR: p1Dir_q <= regWdata;
				REG_P1_IES: p1Ies_q <= regWdata;
				REG_P1_IE:  p1Ie_q  <= regWdata;
				REG_P1_SEL: p1Sel_q <= regWdata;
				REG_P2_OUT: p2Out_q <= regWdata;
				REG_P2_DIR: p2Dir_q <= regWdata;
				REG_P2_IES: p2Ies_q <= regWdata;
				REG_P2_IE:  p2Ie_q  <= regWdata;
				REG_P2_SEL: p2Sel_q <= regWdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			p1Sync1_q <= RESET_BYTE;
			p1Sync2_q <= RESET_BYTE;
			p1Prev_q  <= RESET_BYTE;
			p2Sync1_q <= RESET_BYTE;
			p2Sync2_q <= RESET_BYTE;
			p2Prev_q  <= RESET_BYTE;
			syncFill_q <= '0;
		end else begin
			syncFill_q <= {syncFill_q[SYNC_FILL-2:0], 1'b1};
			p1Sync1_q <= p1PinIn;
			p1Sync2_q <= p1Sync1_q;
			p1Prev_q  <= p1Sync2_q;
			p2Sync1_q <= p2PinIn;
			p2Sync2_q <= p2Sync1_q;
			p2Prev_q  <= p2Sync2_q;
		end
	end

	// edge by select
	// Edges masked until the sync chain holds real pin samples after reset
	assign p1Edge = ((~p1Ies_q & p1Sync2_q & ~p1Prev_q) | (p1Ies_q & ~p1Sync2_q & p1Prev_q))
		& {WIDTH{syncFill_q[SYNC_FILL-1]}};
	assign p2Edge = ((~p2Ies_q & p2Sync2_q & ~p2Prev_q) | (p2Ies_q & ~p2Sync2_q & p2Prev_q))
		& ~P2_UNBONDED & {WIDTH{syncFill_q[SYNC_FILL-1]}};

	// ----------------------------------------------------------------
	// Interrupt flags: hardware set wins over software write
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			p1Ifg_q <= RESET_BYTE;
			p2Ifg_q <= RESET_BYTE;
		end else begin
			if (wrEn && regAddr == REG_P1_IFG)
				p1Ifg_q <= regWdata | p1Edge;
			else
				p1Ifg_q <= p1Ifg_q | p1Edge;
			if (wrEn && regAddr == REG_P2_IFG)
				p2Ifg_q <= regWdata | p2Edge;
			else
				p2Ifg_q <= p2Ifg_q | p2Edge;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			p1IrqReq <= 1'b0;
			p2IrqReq <= 1'b0;
		end else begin
			p1IrqReq <= |(p1Ifg_q & p1Ie_q);
			p2IrqReq <= |(p2Ifg_q & p2Ie_q);
		end
	end

	// ----------------------------------------------------------------
	// Output function mux
	// ----------------------------------------------------------------
	always_comb begin
		p1Mod[0] = 1'b0;
		p1Mod[1] = compareOutputCh0;
		p1Mod[2] = compareOutputCh1;
		p1Mod[3] = compareOutputCh2;
		p1Mod[4] = submainSystemClock;
		p1Mod[5] = compareOutputCh0;
		p1Mod[6] = compareOutputCh1;
		p1Mod[7] = compareOutputCh2;
		p2Mod[0] = auxClock;
		p2Mod[1] = 1'b0;
		p2Mod[2] = comparatorResult;
		p2Mod[3] = compareOutputCh1;
		p2Mod[4] = compareOutputCh2;
		p2Mod[5] = 1'b0;
		p2Mod[6] = 1'b0;
		p2Mod[7] = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			p1PinOut <= RESET_BYTE;
			p1PinOe  <= RESET_BYTE;
			p2PinOut <= RESET_BYTE;
			p2PinOe  <= RESET_BYTE;
		end else begin
			p1PinOut <= (p1Sel_q & p1Mod) | (~p1Sel_q & p1Out_q);
			p2PinOut <= ((p2Sel_q & p2Mod) | (~p2Sel_q & p2Out_q)) & ~P2_UNBONDED;
			p1PinOe  <= p1Dir_q;
			p2PinOe  <= p2Dir_q & ~P2_UNBONDED;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral inputs, gated by select
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			timerExternalClockIn  <= 1'b0;
			timerAlternateClockIn <= 1'b0;
			captureCh0InputA      <= 1'b0;
			captureCh1InputA      <= 1'b0;
			captureCh2InputA      <= 1'b0;
			captureCh0InputB      <= 1'b0;
		end else begin
			timerExternalClockIn  <= p1Sel_q[0] & p1Sync2_q[0];
			captureCh0InputA      <= p1Sel_q[1] & p1Sync2_q[1];
			captureCh1InputA      <= p1Sel_q[2] & p1Sync2_q[2];
			captureCh2InputA      <= p1Sel_q[3] & p1Sync2_q[3];
			timerAlternateClockIn <= p2Sel_q[1] & p2Sync2_q[1];
			captureCh0InputB      <= p2Sel_q[2] & p2Sync2_q[2];
		end
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= RESET_BYTE;
		end else if (regRead) begin
			unique case (regAddr)
				REG_P1_IN:     regRdata <= p1Sync2_q;
				REG_P1_OUT:    regRdata <= p1Out_q;
				REG_P1_DIR:    regRdata <= p1Dir_q;
				REG_P1_IFG:    regRdata <= p1Ifg_q;
				REG_P1_IES:    regRdata <= p1Ies_q;
				REG_P1_IE:     regRdata <= p1Ie_q;
				REG_P1_SEL:    regRdata <= p1Sel_q;
				REG_P2_IN:     regRdata <= p2Sync2_q & ~P2_UNBONDED;
				REG_P2_OUT:    regRdata <= p2Out_q;
				REG_P2_DIR:    regRdata <= p2Dir_q;
				REG_P2_IFG:    regRdata <= p2Ifg_q;
				REG_P2_IES:    regRdata <= p2Ies_q;
				REG_P2_IE:     regRdata <= p2Ie_q;
				REG_P2_SEL:    regRdata <= p2Sel_q;
				REG_FUSE_STAT: begin
					regRdata <= RESET_BYTE;
					regRdata[FS_CHECK_BIT]  <= fuseSenseEn;
					regRdata[FS_BLOWN_BIT]  <= dbgSync2_q[3];
					regRdata[FS_BYPASS_BIT] <= debugBypass;
				end
				default:       regRdata <= RESET_BYTE;
			endcase
		end else begin
			regRdata <= RESET_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Fuse check and debug lock
	// ----------------------------------------------------------------
	// Sync order: 0 power-on, 1 debug access, 2 test pin, 3 fuse blown
	always_ff @(posedge clk) begin
		if (rst) begin
			dbgSync1_q <= 4'h0;
			dbgSync2_q <= 4'h0;
			dbgPrev_q  <= 1'b0;
		end else begin
			dbgSync1_q <= {fuseBlown, testPin, debugAccess, powerOnReset};
			dbgSync2_q <= dbgSync1_q;
			dbgPrev_q  <= dbgSync2_q[1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fuse_q <= FUSE_IDLE;
		end else if (dbgSync2_q[3]) begin
			fuse_q <= FUSE_LOCK;
		end else if (dbgSync2_q[0]) begin
			fuse_q <= FUSE_IDLE;
		end else begin
			unique case (fuse_q)
				FUSE_IDLE:  if (dbgSync2_q[1] && !dbgPrev_q) fuse_q <= FUSE_CHECK;
				FUSE_CHECK: if (!dbgSync2_q[2]) fuse_q <= FUSE_DONE;
				FUSE_DONE:  fuse_q <= FUSE_DONE;
				FUSE_LOCK:  fuse_q <= FUSE_LOCK;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fuseSenseEn <= 1'b0;
			debugBypass <= 1'b0;
			debugGrant  <= 1'b0;
		end else begin
			fuseSenseEn <= (fuse_q == FUSE_CHECK) && dbgSync2_q[2] && !dbgSync2_q[3];
			debugBypass <= (fuse_q == FUSE_LOCK) || dbgSync2_q[3];
			debugGrant  <= dbgSync2_q[1] && fuse_q != FUSE_LOCK && !dbgSync2_q[3];
		end
	end

endmodule : port_pin_function_mux

/* verif/port_mux_checker.sv */
`timescale 1ns/10ps
module port_mux_checker
	import port_mux_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic [ADDR_WIDTH-1:0] regAddr,
	input wire logic [WIDTH-1:0]      regWdata,
	input wire logic                  regWrite,
	input wire logic                  regRead,
	input wire logic [WIDTH-1:0]      regRdata,
	input wire logic [WIDTH-1:0]      p1PinIn,
	input wire logic [WIDTH-1:0]      p1PinOe,
	input wire logic [WIDTH-1:0]      p2PinIn,
	input wire logic [WIDTH-1:0]      p2PinOut,
	input wire logic [WIDTH-1:0]      p2PinOe,
	input wire logic                  timerExternalClockIn,
	input wire logic                  captureCh0InputB,
	input wire logic                  powerOnReset,
	input wire logic                  testPin,
	input wire logic                  fuseBlown,
	input wire logic                  fuseSenseEn,
	input wire logic                  debugBypass,
	input wire logic                  debugGrant
);
	// ----------------------------------------
	// Port, fuse and debug lock behaviour
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_dir_to_oe: assert property (
		regWrite && regAddr == REG_P1_DIR |-> ##2 p1PinOe == $past(regWdata, 2))
		else $error("p1 enable does not follow direction write");
	a_unbonded_low: assert property (
		p2PinOut[7:6] == 2'b00 && p2PinOe[7:6] == 2'b00)
		else $error("unbonded p2 bits driven");
	a_rdata_idle: assert property (
		!regRead |=> regRdata == '0)
		else $error("read data without read");
	a_unmapped_read: assert property (
		regRead && regAddr == 4'h7 |=> regRdata == '0)
		else $error("unmapped read not zero");
	a_extclk_low: assert property (
		(!p1PinIn[0])[*4] |-> !timerExternalClockIn)
		else $error("external clock high with pin low");
	a_capb_low: assert property (
		(!p2PinIn[2])[*4] |-> !captureCh0InputB)
		else $error("capture b high with pin low");
	a_fuse_lock: assert property (
		(fuseBlown && !powerOnReset)[*6] |-> debugBypass && !debugGrant)
		else $error("blown fuse not in bypass");
	a_sense_off: assert property (
		(!testPin)[*5] |-> !fuseSenseEn)
		else $error("sense current with test pin low");
	c_sense: cover property (fuseSenseEn);
	c_bypass: cover property (debugBypass);
	c_dir: cover property (regWrite && regAddr == REG_P1_DIR);
endmodule : port_mux_checker

bind port_pin_function_mux port_mux_checker #(.WIDTH(WIDTH)) port_mux_checker_i (.clk, .rst,
	.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .p1PinIn, .p1PinOe, .p2PinIn,
	.p2PinOut, .p2PinOe, .timerExternalClockIn, .captureCh0InputB, .powerOnReset, .testPin,
	.fuseBlown, .fuseSenseEn, .debugBypass, .debugGrant);

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top
	import port_mux_pkg::*;
;
	logic       clk, rst, regWrite, regRead, p1IrqReq, p2IrqReq;
	logic [3:0] regAddr;
	logic [7:0] regWdata, regRdata, p1PinIn, p1PinOut, p1PinOe, p2PinIn, p2PinOut, p2PinOe;
	logic       compareOutputCh0, compareOutputCh1, compareOutputCh2, submainSystemClock;
	logic       auxClock, comparatorResult, timerExternalClockIn, timerAlternateClockIn;
	logic       captureCh0InputA, captureCh1InputA, captureCh2InputA, captureCh0InputB;
	logic       powerOnReset, debugAccess, testPin, fuseBlown, fuseSenseEn, debugBypass;
	logic       debugGrant;
	logic [7:0] routed;
	logic [5:0] v;
	int         mismatches, nChecks;

	assign routed = {2'b00, timerExternalClockIn, captureCh0InputA, captureCh1InputA,
		captureCh2InputA, timerAlternateClockIn, captureCh0InputB};

	port_pin_function_mux port_pin_function_mux_i (.clk, .rst, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .p1PinIn, .p1PinOut, .p1PinOe, .p2PinIn, .p2PinOut, .p2PinOe,
		.compareOutputCh0, .compareOutputCh1, .compareOutputCh2, .submainSystemClock,
		.auxClock, .comparatorResult, .timerExternalClockIn, .timerAlternateClockIn,
		.captureCh0InputA, .captureCh1InputA, .captureCh2InputA, .captureCh0InputB, .p1IrqReq,
		.p2IrqReq, .powerOnReset, .debugAccess, .testPin, .fuseBlown, .fuseSenseEn,
		.debugBypass, .debugGrant);

	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	// Waits on falling edges so checks see settled outputs
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdata, e);
	endtask : rd
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int i = 0; i < 16; i++)
			rd(4'(i), RESET_BYTE);
	endtask : t_reset
	task automatic t_plain();
		wr(REG_P1_OUT, 8'hA5);
		wr(REG_P1_DIR, 8'hF0);
		@(posedge clk) p1PinIn <= 8'h3C;
		cyc(4);
		chk(p1PinOut, 8'hA5);
		chk(p1PinOe, 8'hF0);
		rd(REG_P1_IN, 8'h3C);
	endtask : t_plain
	task automatic t_periph();
		wr(REG_P1_SEL, 8'hFF);
		wr(REG_P2_SEL, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			v = i ? 6'b101011 : 6'b010100;
			@(posedge clk) {compareOutputCh0, compareOutputCh1, compareOutputCh2,
				submainSystemClock, auxClock, comparatorResult} <= v;
			cyc(3);
			chk(p1PinOut, {v[3], v[4], v[5], v[2], v[3], v[4], v[5], 1'b0});
			chk(p2PinOut, {3'b000, v[3], v[4], v[0], 1'b0, v[1]});
		end
		@(posedge clk) p1PinIn <= 8'h0A;
		p2PinIn <= 8'h04;
		cyc(4);
		chk(routed, 8'h15);
		@(posedge clk) p1PinIn <= 8'h05;
		p2PinIn <= 8'h02;
		cyc(4);
		chk(routed, 8'h2A);
		chk(p1PinOe, 8'hF0);
		wr(REG_P1_SEL, 8'h00);
		wr(REG_P2_SEL, 8'h00);
		cyc(3);
		chk(routed, 8'h00);
	endtask : t_periph
	task automatic t_irq();
		@(posedge clk) p1PinIn <= 8'h02;
		cyc(4);
		wr(REG_P1_IES, 8'h02);
		wr(REG_P1_IE, 8'h01);
		wr(REG_P1_IFG, 8'h00);
		@(posedge clk) p1PinIn <= 8'h01;
		cyc(5);
		rd(REG_P1_IFG, 8'h03);
		chk({7'h00, p1IrqReq}, 8'h01);
		wr(REG_P1_IE, 8'h00);
		cyc(2);
		chk({7'h00, p1IrqReq}, 8'h00);
	endtask : t_irq
	task automatic t_soft();
		wr(REG_P2_DIR, 8'hFF);
		wr(REG_P2_IFG, 8'h00);
		@(posedge clk) p2PinIn <= 8'hC0;
		cyc(5);
		rd(REG_P2_IFG, 8'h00);
		chk(p2PinOe, 8'h3F);
		rd(REG_P2_IN, 8'h00);
		wr(REG_P2_IE, 8'hC0);
		wr(REG_P2_IFG, 8'hC0);
		rd(REG_P2_IFG, 8'hC0);
		chk({7'h00, p2IrqReq}, 8'h01);
	endtask : t_soft
	task automatic t_fuse();
		@(posedge clk) testPin <= 1'b1;
		debugAccess <= 1'b1;
		cyc(6);
		chk({7'h00, fuseSenseEn}, 8'h01);
		rd(REG_FUSE_STAT, 8'h01);
		@(posedge clk) testPin <= 1'b0;
		debugAccess <= 1'b0;
		cyc(6);
		chk({7'h00, fuseSenseEn}, 8'h00);
		@(posedge clk) testPin <= 1'b1;
		debugAccess <= 1'b1;
		cyc(6);
		chk({7'h00, fuseSenseEn}, 8'h00);
		@(posedge clk) powerOnReset <= 1'b1;
		debugAccess <= 1'b0;
		cyc(6);
		@(posedge clk) powerOnReset <= 1'b0;
		debugAccess <= 1'b1;
		cyc(6);
		chk({7'h00, fuseSenseEn}, 8'h01);
		chk({6'h00, debugBypass, debugGrant}, 8'h01);
		@(posedge clk) fuseBlown <= 1'b1;
		cyc(6);
		chk({6'h00, debugBypass, debugGrant}, 8'h02);
		chk({7'h00, fuseSenseEn}, 8'h00);
		rd(REG_FUSE_STAT, 8'h06);
	endtask : t_fuse

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#50us;
		mismatches++;
		final_report();
	end
	initial begin
		{rst, regWrite, regRead, regAddr, regWdata, p1PinIn, p2PinIn} = '0;
		{compareOutputCh0, compareOutputCh1, compareOutputCh2, submainSystemClock} = '0;
		{auxClock, comparatorResult, powerOnReset, debugAccess, testPin, fuseBlown} = '0;
		mismatches = 0;
		nChecks = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_plain();
		t_periph();
		t_irq();
		t_soft();
		t_fuse();
		final_report();
	end
endmodule : tb_top
